// [design/dcf_pkg.sv]
// Shared constants for the dual-clock queue port control.
// Assumes one system clock; all pins are sampled by it.
package dcf_pkg;
  localparam int DATA_W = 18;
  localparam int NARROW_W = 9;
  localparam int DEPTH_DEF = 16;
  localparam int ADDR_W_DEF = 4;
  localparam int OFS_DEF_VAL = 7;
  // Rewind blanking, in read-side edges
  localparam logic [1:0] RT_ZERO_EDGES = 2'h1;
  localparam logic [1:0] RT_NORM_EDGES = 2'h2;
  // Field positions in the synchronised pin vector
  localparam int P_WCLK = 0;
  localparam int P_RCLK = 1;
  localparam int P_WGATE_N = 2;
  localparam int P_RGATE_N = 3;
  localparam int P_LD_N = 4;
  localparam int P_SEN_N = 5;
  localparam int P_SI = 6;
  localparam int P_RT_N = 7;
  localparam int P_PRS_N = 8;
  localparam int P_MRS_N = 9;
  localparam int P_OW = 10;
  localparam int P_PFM = 11;
  localparam int P_RM = 12;
  localparam int P_RSYNC = 13;
  localparam int P_WSYNC = 14;
  localparam int P_DATA = 15;
  localparam int PIN_W = P_DATA + DATA_W;
  // Idle levels: gates inactive, clocks low, full init held
  // Holding init keeps the block out of run until the pins are seen
  localparam logic [PIN_W-1:0] PIN_IDLE = 33'h0000061BC;
  typedef enum logic [1:0] {
    ST_INIT = 2'h1,
    ST_RUN = 2'h2
  } dcf_state_t;
endpackage

// [design/dcf_port_ctrl.sv]
// Port control of a dual-clock queue: write/read ports, threshold flags,
// init-time options, soft clear and rewind.
// Assumes all pins are asynchronous to ref_clk_in and much slower.
// Functional notes
// (RULE1) Read width latched at full init: low 18 bits, high 9 bits.
// (RULE2) Near-empty low while count below empty offset, else high.
// (RULE3) Near-full high while free exceeds full offset, else low.
// (RULE4) Flag timing latched at full init: low async, high sync.
// (RULE5) Soft clear zeroes both pointers and the output register.
// (RULE6) Soft clear keeps modes, programming method and offsets.
// (RULE7) Read data on all 18 bits, or low nine bits in 9-bit mode.
// (RULE8) Read edges count only while the read gate is asserted; rewind and its blanking countdown use ungated read edges.
// (RULE9) Sync read: each enabled read edge pops one word.
// (RULE10) Offset gate low: enabled read edges output offset registers.
// (RULE11) Async read: strobe edge pops; reader holds read gate low.
// (RULE12) Rewind latency latched at full init: low zero, high normal.
// (RULE13) Rewind on a read edge resets the read pointer to zero.
// (RULE14) Rewind shows empty, keeps write pointer, modes and offsets.
// (RULE15) Serial offset shift only while the shift gate is asserted.
// (RULE16) Sync write: each enabled write edge stores one word.
// (RULE17) Async write: strobe edge stores; writer holds write gate.
// (RULE18) Write edges count only while the write gate is asserted.
// (RULE19) Option inputs stay stable after full init.
// (RULE20) Fall-through select latched at init, then serial offset data.
// (RULE21) Empty indicator: empty in standard, output valid in fall-through.
// (RULE22) Writes when full and reads when empty are ignored.
// (RULE23) Sync flag timing updates flags from synchronised count.
`timescale 1ns/1ps
module dcf_port_ctrl #(
  parameter int DEPTH = dcf_pkg::DEPTH_DEF,
  parameter int ADDR_W = dcf_pkg::ADDR_W_DEF
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic full_init_n_in,
  input wire logic soft_clear_n_in,
  input wire logic read_width_select_in,
  input wire logic threshold_flag_timing_select_in,
  input wire logic rewind_latency_select_in,
  input wire logic read_sync_select_in,
  input wire logic write_sync_select_in,
  input wire logic fall_through_select_in,
  input wire logic offset_access_gate_n_in,
  input wire logic offset_shift_gate_n_in,
  input wire logic rewind_request_n_in,
  input wire logic wr_clk_in,
  input wire logic write_gate_n_in,
  input wire logic [dcf_pkg::DATA_W-1:0] data_in,
  input wire logic rd_clk_in,
  input wire logic read_gate_n_in,
  output logic [dcf_pkg::DATA_W-1:0] output_bus_out,
  output logic empty_indicator_out,
  output logic full_indicator_out,
  output logic near_empty_flag_out,
  output logic near_full_flag_out
);
  localparam int OFS_W = ADDR_W + 1;
  localparam logic [OFS_W-1:0] DEPTH_C = OFS_W'(DEPTH);
  localparam logic [OFS_W-1:0] OFS_DEF = OFS_W'(dcf_pkg::OFS_DEF_VAL);
  localparam logic [OFS_W-1:0] ONE_C = OFS_W'(1);

  logic [dcf_pkg::PIN_W-1:0] pin_raw;
  logic [dcf_pkg::PIN_W-1:0] pin_s;
  logic [dcf_pkg::DATA_W-1:0] data_s;
  logic [dcf_pkg::DATA_W-1:0] rdata;
  logic wclk_s, rclk_s, wgate_n_s, rgate_n_s, ld_n_s, sen_n_s, si_s;
  logic rt_n_s, prs_n_s, mrs_n_s;
  dcf_pkg::dcf_state_t state_reg, state_next;
  logic [OFS_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [OFS_W-1:0] empty_ofs_reg, empty_ofs_next;
  logic [OFS_W-1:0] full_ofs_reg, full_ofs_next;
  logic [dcf_pkg::DATA_W-1:0] dout_reg, dout_next;
  logic [1:0] hold_reg, hold_next;
  logic [2*OFS_W:0] chain;
  logic out_valid_reg, out_valid_next, wsel_reg, wsel_next;
  logic rsel_reg, rsel_next, pae_reg, pae_next, paf_reg, paf_next;
  logic ow_reg, ow_next, pfm_reg, pfm_next, rm_reg, rm_next;
  logic fall_through_select_reg, fall_through_select_next, rsync_reg, rsync_next;
  logic wsync_reg, wsync_next, wclk_d_reg, rclk_d_reg;
  logic [OFS_W-1:0] count, free_cnt;
  logic empty_q, full_q, wr_edge, rd_edge, wr_en, rd_en, rt_edge;
  logic shift_en, ofs_wr, q_wr, ofs_rd, q_rd, take, fall_through_select_eff;

  // Narrow port leaves the upper lines low
  function automatic logic [dcf_pkg::DATA_W-1:0] fit_width(
      input logic [dcf_pkg::DATA_W-1:0] d, input logic narrow);
    fit_width = narrow ?
        {{(dcf_pkg::DATA_W-dcf_pkg::NARROW_W){1'b0}},
         d[dcf_pkg::NARROW_W-1:0]} : d; // [RULE7]
  endfunction

  always_comb begin
    pin_raw = {data_in, write_sync_select_in, read_sync_select_in,
               rewind_latency_select_in, threshold_flag_timing_select_in,
               read_width_select_in, full_init_n_in, soft_clear_n_in,
               rewind_request_n_in, fall_through_select_in,
               offset_shift_gate_n_in, offset_access_gate_n_in,
               read_gate_n_in, write_gate_n_in, rd_clk_in, wr_clk_in};
  end

  dcf_sync #(
    .W(dcf_pkg::PIN_W),
    .RST_VAL(dcf_pkg::PIN_IDLE)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in(pin_raw),
    .q_out(pin_s)
  );

  dcf_store #(
    .W(dcf_pkg::DATA_W),
    .DEPTH(DEPTH),
    .ADDR_W(ADDR_W)
  ) u_store (
    .ref_clk_in(ref_clk_in),
    .we_in(q_wr),
    .waddr_in(wr_ptr_reg[ADDR_W-1:0]),
    .wdata_in(data_s),
    .raddr_in(rd_ptr_reg[ADDR_W-1:0]),
    .rdata_out(rdata)
  );

  always_comb begin
    data_s = pin_s[dcf_pkg::P_DATA +: dcf_pkg::DATA_W];
    wclk_s = pin_s[dcf_pkg::P_WCLK];
    rclk_s = pin_s[dcf_pkg::P_RCLK];
    wgate_n_s = pin_s[dcf_pkg::P_WGATE_N];
    rgate_n_s = pin_s[dcf_pkg::P_RGATE_N];
    ld_n_s = pin_s[dcf_pkg::P_LD_N];
    sen_n_s = pin_s[dcf_pkg::P_SEN_N];
    si_s = pin_s[dcf_pkg::P_SI];
    rt_n_s = pin_s[dcf_pkg::P_RT_N];
    prs_n_s = pin_s[dcf_pkg::P_PRS_N];
    mrs_n_s = pin_s[dcf_pkg::P_MRS_N];
    count = wr_ptr_reg - rd_ptr_reg;
    free_cnt = DEPTH_C - count;
    empty_q = (count == '0);
    full_q = (count == DEPTH_C);
    wr_edge = wclk_s & ~wclk_d_reg;
    rd_edge = rclk_s & ~rclk_d_reg;
    // Strobe mode still honours the gate; the far side holds it active
    wr_en = wr_edge & ~wgate_n_s; // [RULE16] [RULE17] [RULE18]
    rd_en = rd_edge & ~rgate_n_s; // [RULE8] [RULE11]
    shift_en = wr_en & ~sen_n_s; // [RULE15]
    ofs_wr = wr_en & sen_n_s & ~ld_n_s;
    q_wr = (state_reg == dcf_pkg::ST_RUN) & mrs_n_s & prs_n_s &
           wr_en & sen_n_s & ld_n_s & ~full_q; // [RULE22]
    rt_edge = rd_edge & ~rt_n_s; // [RULE13]
    ofs_rd = rd_en & ~ld_n_s; // [RULE10]
    q_rd = rd_en & ld_n_s;
    // Strobe read port forces standard timing
    fall_through_select_eff = fall_through_select_reg & rsync_reg;
    take = (hold_reg == 2'h0) & ~empty_q &
           (fall_through_select_eff ? (~out_valid_reg | q_rd) : q_rd); // [RULE9] [RULE22]
    chain = {full_ofs_reg, empty_ofs_reg, si_s};
  end

  always_comb begin
    state_next = state_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    empty_ofs_next = empty_ofs_reg;
    full_ofs_next = full_ofs_reg;
    dout_next = dout_reg;
    hold_next = hold_reg;
    out_valid_next = out_valid_reg;
    wsel_next = wsel_reg;
    rsel_next = rsel_reg;
    pae_next = pae_reg;
    paf_next = paf_reg;
    ow_next = ow_reg;
    pfm_next = pfm_reg;
    rm_next = rm_reg;
    fall_through_select_next = fall_through_select_reg;
    rsync_next = rsync_reg;
    wsync_next = wsync_reg;
    case (state_reg)
      dcf_pkg::ST_INIT: begin
        // Options follow the pins while init is held, frozen at release
        ow_next = pin_s[dcf_pkg::P_OW]; // [RULE1]
        pfm_next = pin_s[dcf_pkg::P_PFM]; // [RULE4]
        rm_next = pin_s[dcf_pkg::P_RM]; // [RULE12]
        fall_through_select_next = si_s; // [RULE20]
        rsync_next = pin_s[dcf_pkg::P_RSYNC];
        wsync_next = pin_s[dcf_pkg::P_WSYNC];
        wr_ptr_next = '0;
        rd_ptr_next = '0;
        dout_next = '0;
        hold_next = 2'h0;
        out_valid_next = 1'b0;
        wsel_next = 1'b0;
        rsel_next = 1'b0;
        empty_ofs_next = OFS_DEF;
        full_ofs_next = OFS_DEF;
        pae_next = 1'b0;
        paf_next = 1'b1;
        if (mrs_n_s) begin
          state_next = dcf_pkg::ST_RUN;
        end
      end
      dcf_pkg::ST_RUN: begin
        if (!mrs_n_s) begin
          state_next = dcf_pkg::ST_INIT;
        end else if (!prs_n_s) begin
          // Offsets and option latches untouched here
          wr_ptr_next = '0; // [RULE5] [RULE6]
          rd_ptr_next = '0; // [RULE5]
          dout_next = '0; // [RULE5]
          hold_next = 2'h0;
          out_valid_next = 1'b0;
          wsel_next = 1'b0;
          rsel_next = 1'b0;
          pae_next = 1'b0;
          paf_next = 1'b1;
        end else begin
          if (shift_en) begin
            // Chain moves up one place; full offset MSB drops out
            full_ofs_next = chain[2*OFS_W-1:OFS_W]; // [RULE15] [RULE20]
            empty_ofs_next = chain[OFS_W-1:0];
          end else if (ofs_wr) begin
            wsel_next = ~wsel_reg;
            if (wsel_reg) begin
              full_ofs_next = data_s[OFS_W-1:0];
            end else begin
              empty_ofs_next = data_s[OFS_W-1:0];
            end
          end else if (q_wr) begin
            wr_ptr_next = wr_ptr_reg + ONE_C; // [RULE16]
          end
          if (rt_edge) begin
            // Write side and offsets are left alone
            rd_ptr_next = '0; // [RULE13] [RULE14]
            out_valid_next = 1'b0; // [RULE14]
            hold_next = rm_reg ? dcf_pkg::RT_NORM_EDGES :
                        dcf_pkg::RT_ZERO_EDGES; // [RULE12]
          end else begin
            if (rd_edge && hold_reg != 2'h0) begin
              hold_next = hold_reg - 2'h1;
            end
            if (ofs_rd) begin
              rsel_next = ~rsel_reg;
              dout_next = fit_width(dcf_pkg::DATA_W'(rsel_reg ?
                  full_ofs_reg : empty_ofs_reg), ow_reg); // [RULE10]
            end else if (take) begin
              rd_ptr_next = rd_ptr_reg + ONE_C; // [RULE9]
              dout_next = fit_width(rdata, ow_reg); // [RULE7]
              out_valid_next = 1'b1;
            end else if (fall_through_select_eff && q_rd && hold_reg == 2'h0) begin
              out_valid_next = 1'b0;
            end
          end
          // Async mode tracks every cycle; sync waits for own edge
          if (!pfm_reg || rd_edge) begin
            pae_next = (count >= empty_ofs_reg); // [RULE2] [RULE23]
          end
          if (!pfm_reg || wr_edge) begin
            paf_next = (free_cnt > full_ofs_reg); // [RULE3] [RULE23]
          end
        end
      end
      default: state_next = dcf_pkg::ST_INIT;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= dcf_pkg::ST_INIT;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      empty_ofs_reg <= OFS_DEF;
      full_ofs_reg <= OFS_DEF;
      dout_reg <= '0;
      hold_reg <= 2'h0;
      out_valid_reg <= 1'b0;
      wsel_reg <= 1'b0;
      rsel_reg <= 1'b0;
      pae_reg <= 1'b0;
      paf_reg <= 1'b1;
      ow_reg <= 1'b0;
      pfm_reg <= 1'b0;
      rm_reg <= 1'b0;
      fall_through_select_reg <= 1'b0;
      rsync_reg <= 1'b1;
      wsync_reg <= 1'b1;
      wclk_d_reg <= 1'b0;
      rclk_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      empty_ofs_reg <= empty_ofs_next;
      full_ofs_reg <= full_ofs_next;
      dout_reg <= dout_next;
      hold_reg <= hold_next;
      out_valid_reg <= out_valid_next;
      wsel_reg <= wsel_next;
      rsel_reg <= rsel_next;
      pae_reg <= pae_next;
      paf_reg <= paf_next;
      ow_reg <= ow_next;
      pfm_reg <= pfm_next;
      rm_reg <= rm_next;
      fall_through_select_reg <= fall_through_select_next;
      rsync_reg <= rsync_next;
      wsync_reg <= wsync_next;
      wclk_d_reg <= wclk_s;
      rclk_d_reg <= rclk_s;
    end
  end

  always_comb begin
    output_bus_out = dout_reg;
    // Standard: low means empty; fall-through: low means word valid
    empty_indicator_out = fall_through_select_eff ? ~out_valid_reg :
        (~empty_q & (hold_reg == 2'h0)); // [RULE21] [RULE14]
    full_indicator_out = fall_through_select_eff ? full_q : ~full_q;
    near_empty_flag_out = pae_reg;
    near_full_flag_out = paf_reg;
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic run_ok;
  assign run_ok = (state_reg == dcf_pkg::ST_RUN) & mrs_n_s;

  a_soft_clear_zero: assert property (run_ok && !prs_n_s |=> // [RULE5]
      wr_ptr_reg == '0 && rd_ptr_reg == '0 && dout_reg == '0)
    else $error("soft clear left pointers or output set");
  a_clear_keeps_ofs: assert property (run_ok && !prs_n_s |=> // [RULE6]
      $stable(empty_ofs_reg) && $stable(full_ofs_reg) && $stable(pfm_reg))
    else $error("soft clear altered offsets or mode");
  a_narrow_upper_low: assert property (ow_reg |-> // [RULE7]
      output_bus_out[dcf_pkg::DATA_W-1:dcf_pkg::NARROW_W] == '0)
    else $error("upper output lines active in narrow mode");
  a_read_gate_off: assert property (run_ok && prs_n_s && rt_n_s && // [RULE8]
      rgate_n_s && !fall_through_select_eff |=> $stable(rd_ptr_reg) && $stable(dout_reg))
    else $error("read taken without read gate");
  a_sync_pop_one: assert property (run_ok && prs_n_s && !rt_edge && // [RULE9]
      !fall_through_select_eff && q_rd && !empty_q && hold_reg == 2'h0 |=>
      rd_ptr_reg == $past(rd_ptr_reg) + ONE_C)
    else $error("enabled read did not pop one word");
  a_offset_read_out: assert property (run_ok && prs_n_s && !rt_edge && // [RULE10]
      ofs_rd && !ow_reg |=> dout_reg[OFS_W-1:0] ==
      ($past(rsel_reg) ? $past(full_ofs_reg) : $past(empty_ofs_reg)))
    else $error("offset read returned wrong value");
  a_rewind_restart: assert property (run_ok && prs_n_s && rt_edge |=> // [RULE13]
      rd_ptr_reg == '0 && hold_reg != 2'h0 && $stable(empty_ofs_reg))
    else $error("rewind did not restart read pointer");
  a_shift_gate_off: assert property (run_ok && sen_n_s && !ofs_wr |=> // [RULE15]
      $stable(empty_ofs_reg) && $stable(full_ofs_reg))
    else $error("offsets changed without shift or load");
  a_full_no_write: assert property (run_ok && prs_n_s && full_q |=> // [RULE22]
      $stable(wr_ptr_reg))
    else $error("write accepted while full");
  a_near_empty_async: assert property (run_ok && prs_n_s && !pfm_reg |=> // [RULE2]
      pae_reg == ($past(count) >= $past(empty_ofs_reg)))
    else $error("near-empty flag disagrees with count");
  a_near_full_async: assert property (run_ok && prs_n_s && !pfm_reg |=> // [RULE3]
      paf_reg == ($past(free_cnt) > $past(full_ofs_reg)))
    else $error("near-full flag disagrees with free space");
endmodule // dcf_port_ctrl

// [design/dcf_store.sv]
// Flip-flop word storage with one write and one read index.
// Assumes the caller guards against overwriting unread words.
`timescale 1ns/1ps
module dcf_store #(
  parameter int W = 18,
  parameter int DEPTH = 16,
  parameter int ADDR_W = 4
) (
  input wire logic ref_clk_in,
  input wire logic we_in,
  input wire logic [ADDR_W-1:0] waddr_in,
  input wire logic [W-1:0] wdata_in,
  input wire logic [ADDR_W-1:0] raddr_in,
  output logic [W-1:0] rdata_out
);
  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] wr_word_next;

  always_comb begin
    wr_word_next = wdata_in;
    rdata_out = mem_reg[raddr_in];
  end

  // No reset: contents are meaningless until written
  always_ff @(posedge ref_clk_in) begin
    if (we_in) begin
      mem_reg[waddr_in] <= wr_word_next;
    end
  end
endmodule // dcf_store

// [design/dcf_sync.sv]
// Two-stage synchroniser for a vector of pins.
// Assumes the bits are independent levels or slow strobes.
`timescale 1ns/1ps
module dcf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d_in;
    q_next = meta_reg;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_reg <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q_out <= q_next;
    end
  end
endmodule // dcf_sync

// [verif/dcf_partner.sv]
// Writer and reader strobe model running on a free 48 ns link clock.
// Assumes go levels from the bench; strobes idle low between frames.
`timescale 1ns/1ps
module dcf_partner (
  input wire logic wr_go_in,
  input wire logic rd_go_in,
  output logic wr_clk_out,
  output logic rd_clk_out,
  output logic wr_done_out,
  output logic rd_done_out
);
  logic link_clk = 1'b0;
  logic wr_clk_reg = 1'b0;
  logic rd_clk_reg = 1'b0;
  logic wr_done_reg = 1'b0;
  logic rd_done_reg = 1'b0;
  always #24 link_clk = ~link_clk;
  // One rising edge per go, high a full link period
  always @(posedge link_clk) begin
    if (wr_go_in && !wr_done_reg && !wr_clk_reg) begin
      wr_clk_reg <= 1'b1;
    end else if (wr_clk_reg) begin
      wr_clk_reg <= 1'b0;
      wr_done_reg <= 1'b1;
    end else if (!wr_go_in) begin
      wr_done_reg <= 1'b0;
    end
  end
  // Read side alike; slow enough for the pin synchronisers
  always @(posedge link_clk) begin
    if (rd_go_in && !rd_done_reg && !rd_clk_reg) begin
      rd_clk_reg <= 1'b1;
    end else if (rd_clk_reg) begin
      rd_clk_reg <= 1'b0;
      rd_done_reg <= 1'b1;
    end else if (!rd_go_in) begin
      rd_done_reg <= 1'b0;
    end
  end
  assign wr_clk_out = wr_clk_reg;
  assign rd_clk_out = rd_clk_reg;
  assign wr_done_out = wr_done_reg;
  assign rd_done_out = rd_done_reg;
endmodule // dcf_partner

// [verif/dcf_port_ctrl_tb.sv]
// Self-checking bench for the queue port control.
// Assumes the partner model makes the write and read strobes.
`timescale 1ns/1ps
`define CHK(got, exp) check(18'(got), 18'(exp))
module dcf_port_ctrl_tb;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic full_init_n = 1'b0;
  logic soft_clear_n = 1'b1;
  logic width_sel = 1'b0;
  logic timing_sel = 1'b0;
  logic rewind_sel = 1'b0;
  logic sync_sel = 1'b1;
  logic ft_sel = 1'b0;
  logic ofs_gate_n = 1'b1;
  logic shift_gate_n = 1'b1;
  logic rewind_n = 1'b1;
  logic wr_gate_n = 1'b0;
  logic rd_gate_n = 1'b0;
  logic [17:0] data = '0;
  logic wr_go = 1'b0;
  logic rd_go = 1'b0;
  logic wr_clk, rd_clk, wr_done, rd_done;
  logic [17:0] q;
  logic empty_ind, full_ind, near_empty, near_full;
  int n_fail = 0;
  int cmp_count = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  dcf_port_ctrl DUT (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .full_init_n_in(full_init_n),
    .soft_clear_n_in(soft_clear_n),
    .read_width_select_in(width_sel),
    .threshold_flag_timing_select_in(timing_sel),
    .rewind_latency_select_in(rewind_sel),
    .read_sync_select_in(sync_sel),
    .write_sync_select_in(sync_sel),
    .fall_through_select_in(ft_sel),
    .offset_access_gate_n_in(ofs_gate_n),
    .offset_shift_gate_n_in(shift_gate_n),
    .rewind_request_n_in(rewind_n),
    .wr_clk_in(wr_clk),
    .write_gate_n_in(wr_gate_n),
    .data_in(data),
    .rd_clk_in(rd_clk),
    .read_gate_n_in(rd_gate_n),
    .output_bus_out(q),
    .empty_indicator_out(empty_ind),
    .full_indicator_out(full_ind),
    .near_empty_flag_out(near_empty),
    .near_full_flag_out(near_full)
  );
  dcf_partner far_end (
    .wr_go_in(wr_go),
    .rd_go_in(rd_go),
    .wr_clk_out(wr_clk),
    .rd_clk_out(rd_clk),
    .wr_done_out(wr_done),
    .rd_done_out(rd_done)
  );
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A strobe frame takes up to two link periods, about 20 clocks
  task automatic wait_done(input bit rd, input bit lvl);
    int i;
    for (i = 0; i < 60; i++) begin
      if ((rd ? rd_done : wr_done) === lvl) break;
      @(posedge ref_clk_in);
    end
    if (i == 60) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic strobe(input bit rd);
    if (rd) begin
      rd_go <= 1'b1;
    end else begin
      wr_go <= 1'b1;
    end
    @(posedge ref_clk_in);
    wait_done(rd, 1'b1);
    if (rd) begin
      rd_go <= 1'b0;
    end else begin
      wr_go <= 1'b0;
      data <= ~data;
    end
    wait_done(rd, 1'b0);
    repeat (2) @(posedge ref_clk_in);
  endtask
  task automatic push(input logic [17:0] d);
    data <= d;
    strobe(1'b0);
  endtask
  // Options then stay put until the next init, except ft_sel, which later carries serial offset bits
  task automatic init(input logic ow, threshold_flag_timing_select, rm, sync, ft);
    full_init_n <= 1'b0;
    width_sel <= ow;
    timing_sel <= threshold_flag_timing_select;
    rewind_sel <= rm;
    sync_sel <= sync;
    ft_sel <= ft;
    repeat (6) @(posedge ref_clk_in);
    full_init_n <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
  endtask
  function automatic logic [17:0] word(input int k);
    return 18'(k * 4711 + 257);
  endfunction
  // Async flags only: checks flags after every word
  task automatic fill(input int n);
    for (int i = 1; i <= n; i++) begin
      push(word(i - 1));
      `CHK(near_empty, i >= 7);
      `CHK(near_full, i < 9);
      `CHK(full_ind, i < 16);
      `CHK(empty_ind, 1'b1);
    end
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    `CHK(q, 18'h00000);
    `CHK({near_full, near_empty, empty_ind}, 3'h4);
    init(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    fill(16);
    push(18'h15555);
    for (int j = 0; j < 16; j++) begin
      strobe(1'b1);
      `CHK(q, word(j));
      `CHK(near_empty, 15 - j >= 7);
      `CHK(empty_ind, j < 15);
    end
    strobe(1'b1);
    `CHK(q, word(15));
    wr_gate_n <= 1'b1;
    push(18'h2AAAA);
    wr_gate_n <= 1'b0;
    `CHK(empty_ind, 1'b0);
    push(18'h0F0F0);
    rd_gate_n <= 1'b1;
    strobe(1'b1);
    `CHK(q, word(15));
    rd_gate_n <= 1'b0;
    strobe(1'b1);
    `CHK(q, 18'h0F0F0);
    ofs_gate_n <= 1'b0;
    repeat (2) begin
      strobe(1'b1);
      `CHK(q, dcf_pkg::OFS_DEF_VAL);
    end
    ofs_gate_n <= 1'b1;
    push(18'h11111);
    soft_clear_n <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    soft_clear_n <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    `CHK(q, 18'h00000);
    `CHK(empty_ind, 1'b0);
    // Offsets must survive the clear for the flag figures to hold
    fill(7);
    for (int j = 0; j < 3; j++) begin
      strobe(1'b1);
    end
    `CHK(q, word(2));
    rewind_n <= 1'b0;
    strobe(1'b1);
    rewind_n <= 1'b1;
    `CHK(empty_ind, 1'b0);
    strobe(1'b1);
    strobe(1'b1);
    `CHK(q, word(0));
    `CHK(near_empty, 1'b0);
    // Parallel load: empty offset first, then full offset
    ofs_gate_n <= 1'b0;
    push(18'h3FFE5);
    push(18'h0000C);
    strobe(1'b1);
    `CHK(q, 18'h00005);
    strobe(1'b1);
    `CHK(q, 18'h0000C);
    `CHK({near_empty, near_full}, 2'h2);
    ofs_gate_n <= 1'b1;
    shift_gate_n <= 1'b0;
    // Ten serial bits, full offset MSB first: full 2, empty 3
    for (int b = 9; b >= 0; b--) begin
      ft_sel <= 1'(10'h043 >> b);
      push(18'h3FFFF);
    end
    shift_gate_n <= 1'b1;
    ofs_gate_n <= 1'b0;
    strobe(1'b1);
    `CHK(q, 18'h00003);
    strobe(1'b1);
    `CHK(q, 18'h00002);
    `CHK({near_empty, near_full}, 2'h3);
    ofs_gate_n <= 1'b1;
    init(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 8; k++) begin
      push(word(k) | 18'h3FE00);
    end
    `CHK(near_empty, 1'b0);
    strobe(1'b1);
    `CHK(q, word(0) & 18'h001FF);
    `CHK(near_empty, 1'b1);
    rewind_n <= 1'b0;
    strobe(1'b1);
    rewind_n <= 1'b1;
    repeat (3) strobe(1'b1);
    `CHK(q, word(0) & 18'h001FF);
    init(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    push(18'h2D2D2);
    repeat (4) @(posedge ref_clk_in);
    `CHK(empty_ind, 1'b0);
    `CHK(q, 18'h2D2D2);
    wrap_up();
  end
endmodule // dcf_port_ctrl_tb
